// ### rtl/ucm_map.svh
`ifndef UCM_MAP_SVH
`define UCM_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define UCM_OFF_CMD 9'h000
`define UCM_OFF_CFG 9'h004
`define UCM_OFF_IER 9'h008
`define UCM_OFF_IDR 9'h00C
`define UCM_OFF_IMR 9'h010
`define UCM_OFF_CSR 9'h014
`define UCM_OFF_RHR 9'h018
`define UCM_OFF_THR 9'h01C
`define UCM_OFF_BRG 9'h020
`define UCM_OFF_RTO 9'h024
`define UCM_OFF_TTG 9'h028
`define UCM_OFF_FIDI 9'h040
`define UCM_OFF_NER 9'h044
`define UCM_OFF_IF 9'h04C
`define UCM_OFF_EVCLR 9'h050

// ****************************************************************
// command bit positions
// ****************************************************************
`define UCM_CMD_RX_RST 2
`define UCM_CMD_TX_RST 3
`define UCM_CMD_RX_ON 4
`define UCM_CMD_RX_OFF 5
`define UCM_CMD_TX_ON 6
`define UCM_CMD_TX_OFF 7
`define UCM_CMD_STA_CLR 8
`define UCM_CMD_BRK_GO 9
`define UCM_CMD_BRK_END 10
`define UCM_CMD_TO_START 11
`define UCM_CMD_ADDR 12
`define UCM_CMD_IT_CLR 13
`define UCM_CMD_NEGACK_FLAG_CLR 14
`define UCM_CMD_TO_REARM 15
`define UCM_CMD_DTR_ON 16
`define UCM_CMD_DTR_OFF 17
`define UCM_CMD_RTS_ON 18
`define UCM_CMD_RTS_OFF 19

// ****************************************************************
// line configuration field positions
// ****************************************************************
`define UCM_CFG_MODE_LO 0
`define UCM_CFG_CLKS_LO 4
`define UCM_CFG_CHAR_LENGTH_FIELD_LO 6
`define UCM_CFG_PAR_LO 9
`define UCM_CFG_MODE9 17
`define UCM_CFG_OVER 19

// ****************************************************************
// status bit positions
// ****************************************************************
`define UCM_ST_RXRDY 0
`define UCM_ST_TXRDY 1
`define UCM_ST_BREAK_RECEIVED_FLAG 2
`define UCM_ST_OVERRUN_ERROR_FLAG 5
`define UCM_ST_FRAME 6
`define UCM_ST_PARITY_ERROR_FLAG 7
`define UCM_ST_TIMEOUT 8
`define UCM_ST_TXEMPTY 9
`define UCM_ST_ITER 10
`define UCM_ST_NEGACK_FLAG 13
`define UCM_ST_MASK 32'h000027E7

// ****************************************************************
// reset values and timing counts
// ****************************************************************
`define UCM_RST_FIDI 11'h174
`define UCM_RST_ZERO 32'h00000000
`define UCM_RST_PIN 1'b1
`define UCM_PRE_DIV 3'h7
`define UCM_MARK_BITS 4'hC
`define UCM_OS16_LAST 4'hF
`define UCM_OS8_LAST 4'h7
`define UCM_BASE_BITS 4'h5
`define UCM_NINE_BITS 4'h9
`define UCM_FRAME_XTRA 4'h2

`endif

// ### rtl/ucm_pkg.sv
package ucm_pkg;

    typedef enum logic [1:0] {
        UCM_BRK_IDLE = 2'b00,
        UCM_BRK_WAIT = 2'b01,
        UCM_BRK_LOW = 2'b10,
        UCM_BRK_MARK = 2'b11
    } ucm_brk_e;

    typedef enum logic [3:0] {
        UCM_MODE_NORMAL = 4'b0000,
        UCM_MODE_RS485 = 4'b0001,
        UCM_MODE_HANDSHAKE = 4'b0010,
        UCM_MODE_MODEM = 4'b0011,
        UCM_MODE_CARD_T0 = 4'b0100,
        UCM_MODE_CARD_T1 = 4'b0110,
        UCM_MODE_INFRARED = 4'b1000
    } ucm_mode_e;

    typedef enum logic [1:0] {
        UCM_CLK_MASTER = 2'b00,
        UCM_CLK_DIVIDED = 2'b01,
        UCM_CLK_EXTERNAL = 2'b11
    } ucm_clk_e;

    typedef struct packed {
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
        logic [31:0] cfg;
        logic [15:0] cd;
        logic [15:0] rto;
        logic [7:0] ttg;
        logic [10:0] fidi;
        logic [7:0] irf;
        logic [31:0] imr;
        logic [31:0] sts;
        logic [8:0] rhr;
        logic [7:0] ner;
        logic addr_pend;
        logic rx_on;
        logic tx_on;
        logic dtr_b;
        logic rts_b;
        logic rts_pin;
        logic rx_rst;
        logic tx_rst;
        logic to_start;
        logic to_rearm;
        logic thr_valid;
        logic [8:0] thr_data;
        logic thr_addr;
        ucm_brk_e brk;
        logic brk_stop;
        logic [3:0] brk_cnt;
        logic [2:0] pre_cnt;
        logic [15:0] cd_cnt;
        logic [3:0] os_cnt;
        logic bit_tick;
        ucm_mode_e op_mode;
        ucm_clk_e clk_src;
        logic [3:0] data_bits;
        logic [31:0] rdata;
        logic irq;
    } ucm_state_s;

endpackage

// ### rtl/ucm_ctrl.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "ucm_map.svh"

module ucm_ctrl (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [8:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic sck_pin,
    input wire logic ev_rx_char,
    input wire logic [8:0] ev_rx_data,
    input wire logic ev_parity_err,
    input wire logic ev_frame_err,
    input wire logic ev_overrun,
    input wire logic ev_rx_break,
    input wire logic ev_timeout,
    input wire logic ev_iteration,
    input wire logic ev_negack_flag,
    input wire logic tx_ready_lvl,
    input wire logic tx_empty_lvl,
    output logic rx_enabled,
    output logic tx_enabled,
    output logic rx_reset,
    output logic tx_reset,
    output logic idle_timer_start,
    output logic idle_timer_rearm,
    output logic [15:0] idle_limit,
    output logic [7:0] gap_length,
    output logic [10:0] clock_ratio,
    output logic [7:0] ir_filter,
    output logic tx_char_valid,
    output logic [8:0] tx_char_data,
    output logic tx_char_addr,
    output logic line_break,
    output logic line_mark,
    output logic bit_tick,
    output ucm_pkg::ucm_mode_e op_mode,
    output ucm_pkg::ucm_clk_e clk_src,
    output logic [3:0] data_bits,
    output logic [31:0] line_cfg,
    output logic dtr_b,
    output logic rts_b,
    output logic irq
);
    import ucm_pkg::*;

    ucm_state_s st;
    ucm_state_s next_st;

    // ************************************************************
    // decode helpers
    // ************************************************************

    // address match
    function automatic logic hit(input logic [8:0] a,
                                 input logic [8:0] off);
        hit = (a == off);
    endfunction

    // parity field 11x selects multidrop
    function automatic logic multidrop(input logic [31:0] cfg);
        multidrop = (cfg[`UCM_CFG_PAR_LO+2] &&
                     cfg[`UCM_CFG_PAR_LO+1]);
    endfunction

    // smart-card protocol modes
    function automatic logic smart_card(input ucm_mode_e m);
        smart_card = (m == UCM_MODE_CARD_T0) ||
                     (m == UCM_MODE_CARD_T1);
    endfunction

    // reserved mode codes fall back to normal
    function automatic ucm_mode_e mode_of(input logic [3:0] c);
        case (c)
            4'h0: mode_of = UCM_MODE_NORMAL;
            4'h1: mode_of = UCM_MODE_RS485;
            4'h2: mode_of = UCM_MODE_HANDSHAKE;
            4'h3: mode_of = UCM_MODE_MODEM;
            4'h4: mode_of = UCM_MODE_CARD_T0;
            4'h6: mode_of = UCM_MODE_CARD_T1;
            4'h8: mode_of = UCM_MODE_INFRARED;
            default: mode_of = UCM_MODE_NORMAL;
        endcase
    endfunction

    // reserved clock code falls back to the master clock
    function automatic ucm_clk_e clk_of(input logic [1:0] c);
        case (c)
            2'h1: clk_of = UCM_CLK_DIVIDED;
            2'h3: clk_of = UCM_CLK_EXTERNAL;
            default: clk_of = UCM_CLK_MASTER;
        endcase
    endfunction

    // ************************************************************
    // next state
    // ************************************************************

    // next state
    always_comb begin
        logic wr_cmd;
        logic [31:0] cmd;
        logic [31:0] clr;
        logic [31:0] set;
        logic src_tick;
        logic [3:0] os_last;
        logic [3:0] char_bits;

        next_st = st;
        wr_cmd = reg_wr && hit(reg_addr, `UCM_OFF_CMD);
        cmd = wr_cmd ? reg_wdata : `UCM_RST_ZERO;
        clr = `UCM_RST_ZERO;
        set = `UCM_RST_ZERO;
        src_tick = 1'b0;
        os_last = `UCM_OS16_LAST;
        char_bits = st.data_bits + `UCM_FRAME_XTRA;

        // external clock passes two flops, third for edge
        next_st.sck_s1 = sck_pin;
        next_st.sck_s2 = st.sck_s1;
        next_st.sck_s3 = st.sck_s2;

        // one-cycle pulses default low
        next_st.rx_rst = cmd[`UCM_CMD_RX_RST];
        next_st.tx_rst = cmd[`UCM_CMD_TX_RST];
        next_st.to_start = cmd[`UCM_CMD_TO_START];
        next_st.to_rearm = cmd[`UCM_CMD_TO_REARM];
        next_st.thr_valid = 1'b0;
        next_st.bit_tick = 1'b0;

        // enables, disable wins
        if (cmd[`UCM_CMD_RX_OFF]) begin
            next_st.rx_on = 1'b0;
        end else if (cmd[`UCM_CMD_RX_ON]) begin
            next_st.rx_on = 1'b1;
        end
        if (cmd[`UCM_CMD_TX_OFF]) begin
            next_st.tx_on = 1'b0;
        end else if (cmd[`UCM_CMD_TX_ON]) begin
            next_st.tx_on = 1'b1;
        end

        // modem control pins, deassert dominates
        if (cmd[`UCM_CMD_DTR_OFF]) begin
            next_st.dtr_b = 1'b1;
        end else if (cmd[`UCM_CMD_DTR_ON]) begin
            next_st.dtr_b = 1'b0;
        end
        if (cmd[`UCM_CMD_RTS_OFF]) begin
            next_st.rts_b = 1'b1;
        end else if (cmd[`UCM_CMD_RTS_ON]) begin
            next_st.rts_b = 1'b0;
        end
        // line driver control follows transmitter in RS485
        if (st.op_mode == UCM_MODE_RS485) begin
            next_st.rts_pin = ~tx_empty_lvl;
        end else begin
            next_st.rts_pin = next_st.rts_b;
        end

        // status clears
        if (cmd[`UCM_CMD_STA_CLR]) begin
            clr[`UCM_ST_PARITY_ERROR_FLAG] = 1'b1;
            clr[`UCM_ST_FRAME] = 1'b1;
            clr[`UCM_ST_OVERRUN_ERROR_FLAG] = 1'b1;
            clr[`UCM_ST_BREAK_RECEIVED_FLAG] = 1'b1;
        end
        clr[`UCM_ST_TIMEOUT] = cmd[`UCM_CMD_TO_START];
        clr[`UCM_ST_ITER] = cmd[`UCM_CMD_IT_CLR] &&
                            smart_card(st.op_mode);
        clr[`UCM_ST_NEGACK_FLAG] = cmd[`UCM_CMD_NEGACK_FLAG_CLR];
        if (reg_wr && hit(reg_addr, `UCM_OFF_EVCLR)) begin
            clr = clr | reg_wdata;
        end
        if (reg_rd && hit(reg_addr, `UCM_OFF_RHR)) begin
            clr[`UCM_ST_RXRDY] = 1'b1;
        end

        // events set sticky bits; set beats clear
        set[`UCM_ST_RXRDY] = ev_rx_char;
        set[`UCM_ST_BREAK_RECEIVED_FLAG] = ev_rx_break;
        set[`UCM_ST_OVERRUN_ERROR_FLAG] = ev_overrun;
        set[`UCM_ST_FRAME] = ev_frame_err;
        set[`UCM_ST_PARITY_ERROR_FLAG] = ev_parity_err;
        set[`UCM_ST_TIMEOUT] = ev_timeout;
        set[`UCM_ST_ITER] = ev_iteration;
        set[`UCM_ST_NEGACK_FLAG] = ev_negack_flag;
        next_st.sts = ((st.sts & ~clr) | set) & `UCM_ST_MASK;
        next_st.sts[`UCM_ST_TXRDY] = tx_ready_lvl;
        next_st.sts[`UCM_ST_TXEMPTY] = tx_empty_lvl;
        if (ev_rx_char) begin
            next_st.rhr = ev_rx_data;
        end
        if (ev_parity_err && (st.ner != 8'hFF)) begin
            next_st.ner = st.ner + 8'h01;
        end

        // multidrop address mark
        if (cmd[`UCM_CMD_ADDR] && multidrop(st.cfg)) begin
            next_st.addr_pend = 1'b1;
        end
        if (reg_wr && hit(reg_addr, `UCM_OFF_THR)) begin
            next_st.thr_valid = 1'b1;
            next_st.thr_data = reg_wdata[8:0];
            next_st.thr_addr = st.addr_pend;
            next_st.addr_pend = 1'b0;
        end
        if (cmd[`UCM_CMD_TX_RST]) begin
            next_st.addr_pend = 1'b0;
        end

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                `UCM_OFF_CFG: next_st.cfg = reg_wdata;
                `UCM_OFF_IER: next_st.imr = st.imr |
                    (reg_wdata & `UCM_ST_MASK);
                `UCM_OFF_IDR: next_st.imr = st.imr & ~reg_wdata;
                `UCM_OFF_BRG: next_st.cd = reg_wdata[15:0];
                `UCM_OFF_RTO: next_st.rto = reg_wdata[15:0];
                `UCM_OFF_TTG: next_st.ttg = reg_wdata[7:0];
                `UCM_OFF_FIDI: next_st.fidi = reg_wdata[10:0];
                `UCM_OFF_IF: next_st.irf = reg_wdata[7:0];
                default: next_st.cd = st.cd;
            endcase
        end

        // decoded configuration fields
        next_st.op_mode = mode_of(next_st.cfg[3:0]);
        next_st.clk_src = clk_of(next_st.cfg[5:4]);
        if (next_st.cfg[`UCM_CFG_MODE9]) begin
            next_st.data_bits = `UCM_NINE_BITS;
        end else begin
            next_st.data_bits = `UCM_BASE_BITS +
                {2'b00, next_st.cfg[7:6]};
        end

        // source tick from the selected clock
        next_st.pre_cnt = st.pre_cnt + 3'h1;
        case (st.clk_src)
            UCM_CLK_MASTER: src_tick = 1'b1;
            UCM_CLK_DIVIDED: src_tick =
                (st.pre_cnt == `UCM_PRE_DIV);
            UCM_CLK_EXTERNAL: src_tick =
                st.sck_s2 && !st.sck_s3;
            default: src_tick = 1'b1;
        endcase

        // rate and oversampling divide
        if (st.cfg[`UCM_CFG_OVER]) begin
            os_last = `UCM_OS8_LAST;
        end
        if (src_tick && (st.cd != 16'h0000)) begin
            if (st.cd_cnt >= st.cd - 16'h0001) begin
                next_st.cd_cnt = 16'h0000;
                if (st.os_cnt >= os_last) begin
                    next_st.os_cnt = 4'h0;
                    next_st.bit_tick = 1'b1;
                end else begin
                    next_st.os_cnt = st.os_cnt + 4'h1;
                end
            end else begin
                next_st.cd_cnt = st.cd_cnt + 16'h0001;
            end
        end

        // break sequencing on the transmit line
        if (cmd[`UCM_CMD_BRK_END] && (st.brk == UCM_BRK_LOW)) begin
            next_st.brk_stop = 1'b1;
        end
        case (st.brk)
            UCM_BRK_IDLE: begin
                if (cmd[`UCM_CMD_BRK_GO]) begin
                    next_st.brk = UCM_BRK_WAIT;
                end
            end
            UCM_BRK_WAIT: begin
                if (tx_empty_lvl) begin
                    next_st.brk = UCM_BRK_LOW;
                    next_st.brk_cnt = 4'h0;
                    next_st.brk_stop = 1'b0;
                end
            end
            UCM_BRK_LOW: begin
                if (st.bit_tick && (st.brk_cnt < char_bits)) begin
                    next_st.brk_cnt = st.brk_cnt + 4'h1;
                end
                if (next_st.brk_stop && (st.brk_cnt >= char_bits)) begin
                    next_st.brk = UCM_BRK_MARK;
                    next_st.brk_cnt = 4'h0;
                    next_st.brk_stop = 1'b0;
                end
            end
            UCM_BRK_MARK: begin
                if (st.bit_tick) begin
                    next_st.brk_cnt = st.brk_cnt + 4'h1;
                    if (st.brk_cnt == `UCM_MARK_BITS - 4'h1) begin
                        next_st.brk = UCM_BRK_IDLE;
                    end
                end
            end
            default: next_st.brk = UCM_BRK_IDLE;
        endcase
        if (cmd[`UCM_CMD_TX_RST]) begin
            next_st.brk = UCM_BRK_IDLE;
            next_st.brk_stop = 1'b0;
        end

        // read data for one cycle
        next_st.rdata = `UCM_RST_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                `UCM_OFF_CFG: next_st.rdata = st.cfg;
                `UCM_OFF_IMR: next_st.rdata = st.imr;
                `UCM_OFF_CSR: next_st.rdata = st.sts;
                `UCM_OFF_RHR: next_st.rdata = {23'h0, st.rhr};
                `UCM_OFF_BRG: next_st.rdata = {16'h0, st.cd};
                `UCM_OFF_RTO: next_st.rdata = {16'h0, st.rto};
                `UCM_OFF_TTG: next_st.rdata = {24'h0, st.ttg};
                `UCM_OFF_FIDI: next_st.rdata = {21'h0, st.fidi};
                `UCM_OFF_NER: next_st.rdata = {24'h0, st.ner};
                `UCM_OFF_IF: next_st.rdata = {24'h0, st.irf};
                `UCM_OFF_EVCLR: next_st.rdata = st.sts;
                default: next_st.rdata = `UCM_RST_ZERO;
            endcase
        end
        if (reg_rd && hit(reg_addr, `UCM_OFF_NER)) begin
            next_st.ner = 8'h00;
        end

        // level interrupt from unmasked status
        next_st.irq = |(next_st.sts & st.imr);
    end

    // ************************************************************
    // state register
    // ************************************************************

    // state register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.fidi <= `UCM_RST_FIDI;
            st.dtr_b <= `UCM_RST_PIN;
            st.rts_b <= `UCM_RST_PIN;
            st.rts_pin <= `UCM_RST_PIN;
            st.brk <= UCM_BRK_IDLE;
            st.op_mode <= UCM_MODE_NORMAL;
            st.clk_src <= UCM_CLK_MASTER;
            st.data_bits <= `UCM_BASE_BITS;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    // outputs from state fields
    assign reg_rdata = st.rdata;
    assign rx_enabled = st.rx_on;
    assign tx_enabled = st.tx_on;
    assign rx_reset = st.rx_rst;
    assign tx_reset = st.tx_rst;
    assign idle_timer_start = st.to_start;
    assign idle_timer_rearm = st.to_rearm;
    assign idle_limit = st.rto;
    assign gap_length = st.ttg;
    assign clock_ratio = st.fidi;
    assign ir_filter = st.irf;
    assign tx_char_valid = st.thr_valid;
    assign tx_char_data = st.thr_data;
    assign tx_char_addr = st.thr_addr;
    assign line_break = (st.brk == UCM_BRK_LOW);
    assign line_mark = (st.brk == UCM_BRK_MARK);
    assign bit_tick = st.bit_tick;
    assign op_mode = st.op_mode;
    assign clk_src = st.clk_src;
    assign data_bits = st.data_bits;
    assign line_cfg = st.cfg;
    assign dtr_b = st.dtr_b;
    assign rts_b = st.rts_pin;
    assign irq = st.irq;

endmodule

// ### sim/ucm_ctrl_chk.sv
`timescale 1ns/1ps

module ucm_ctrl_chk (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [8:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic tx_empty_lvl,
    input wire logic rx_enabled,
    input wire logic tx_enabled,
    input wire logic rx_reset,
    input wire logic tx_reset,
    input wire logic idle_timer_start,
    input wire logic line_break,
    input wire ucm_pkg::ucm_mode_e op_mode,
    input wire logic dtr_b,
    input wire logic rts_b,
    input wire logic irq
);
    import ucm_pkg::*;
    logic cw;

    // ******************************************************
    // command decode
    // ******************************************************
    assign cw = reg_wr && (reg_addr == 9'h000);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    rx_reset_pulse_a: assert property (cw && reg_wdata[2] |=> rx_reset)
        else $error("rx reset missing");
    tx_reset_pulse_a: assert property (cw && reg_wdata[3] |=> tx_reset)
        else $error("tx reset missing");
    rx_enable_a: assert property (cw && reg_wdata[4] && !reg_wdata[5]
        |=> rx_enabled) else $error("rx not on");
    rx_disable_a: assert property (cw && reg_wdata[5] |=> !rx_enabled)
        else $error("rx not off");
    tx_disable_a: assert property (cw && reg_wdata[7] |=> !tx_enabled)
        else $error("tx not off");
    idle_start_a: assert property (cw && reg_wdata[11]
        |=> idle_timer_start) else $error("idle start missing");
    dtr_drive_a: assert property (cw && (reg_wdata[17:16] != 2'h0)
        |=> dtr_b == $past(reg_wdata[17])) else $error("dtr level wrong");
    rts_drive_a: assert property (cw && (reg_wdata[19:18] != 2'h0)
        && (op_mode != UCM_MODE_RS485) |=> rts_b == $past(reg_wdata[19]))
        else $error("rts level wrong");
    break_gate_a: assert property ($rose(line_break) |-> $past(tx_empty_lvl))
        else $error("early break");
    reserved_read_a: assert property (reg_rd && (reg_addr inside {9'h000,
        9'h008, 9'h00C, 9'h01C, [9'h02C:9'h03C], 9'h048, [9'h05C:9'h1FC]})
        |=> reg_rdata == 32'h0) else $error("reserved read not zero");
    read_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("stray read data");

    cover property ($rose(line_break));
    cover property ($rose(irq));
    cover property (cw && reg_wdata[4] ##1 rx_enabled);
endmodule

bind ucm_ctrl ucm_ctrl_chk i_chk (.*);

// ### sim/ucm_peer.sv
`timescale 1ns/1ps

module ucm_peer (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] ev_req,
    input wire logic tx_char_valid,
    output logic [7:0] ev,
    output logic [8:0] rx_data,
    output logic tx_empty_lvl,
    output logic tx_ready_lvl,
    output logic sck_pin
);
    logic [5:0] busy;

    // ******************************************************
    // serial engine stand-in
    // ******************************************************
    // events echo a cycle late; a character keeps it busy
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev <= 8'h00;
            busy <= 6'h00;
        end else begin
            ev <= ev_req;
            if (tx_char_valid) begin
                busy <= 6'h28;
            end else if (busy != 6'h00) begin
                busy <= busy - 6'h01;
            end
        end
    end

    // data scrambled off its strobe
    assign rx_data = ev[0] ? 9'h1A5 : ~9'h1A5;
    assign tx_empty_lvl = (busy == 6'h00);
    assign tx_ready_lvl = (busy < 6'h20);
    assign sck_pin = busy[1]; // still outside a frame
endmodule

// ### sim/test_usart_control_and_mode_regs.sv
`timescale 1ns/1ps
`define CHK(a, e) begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
        error_cnt++; \
        $display("mismatch at %0t: got %h exp %h", $time, (a), (e)); \
    end \
end

module test_usart_control_and_mode_regs;
    import ucm_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [8:0] reg_addr = 9'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] ev_req = 8'h00;
    logic [7:0] ev;
    logic [8:0] rx_data;
    logic [31:0] reg_rdata, line_cfg, d;
    logic rx_enabled, tx_enabled, rx_reset, tx_reset, idle_timer_start;
    logic tx_char_valid, tx_char_addr, line_break, line_mark, dtr_b, rts_b;
    logic irq, tx_empty_lvl, tx_ready_lvl, sck_pin;
    logic [3:0] data_bits;
    ucm_mode_e op_mode;
    ucm_clk_e clk_src;
    int error_cnt = 0;
    int cmp_count = 0;
    int i, n;
    localparam logic [8:0] reg_at [7] = '{9'h010, 9'h018, 9'h020, 9'h024,
        9'h028, 9'h040, 9'h04C};
    localparam logic [31:0] rst_at [7] = '{0, 0, 0, 0, 0, 32'h174, 0};
    localparam logic [31:0] max_at [7] = '{0, 0, 32'hFFFF, 32'hFFFF,
        32'hFF, 32'h7FF, 32'hFF};
    localparam logic [8:0] zero_at [11] = '{9'h000, 9'h008, 9'h00C, 9'h01C,
        9'h02C, 9'h03C, 9'h048, 9'h05C, 9'h0FC, 9'h100, 9'h128};
    localparam logic [31:0] cmd_at [7] = '{32'h10, 32'h30, 32'h50, 32'hE0,
        32'h50010, 32'hF0000, 32'h20};
    localparam logic [3:0] pin_at [7] = '{4'hB, 4'h3, 4'hF, 4'h3, 4'h8,
        4'hB, 4'h3};

    ucm_ctrl i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sck_pin(sck_pin), .ev_rx_char(ev[0]),
        .ev_rx_data(rx_data), .ev_parity_err(ev[1]), .ev_frame_err(ev[2]),
        .ev_overrun(ev[3]), .ev_rx_break(ev[4]), .ev_timeout(ev[5]),
        .ev_iteration(ev[6]), .ev_negack_flag(ev[7]), .tx_ready_lvl(tx_ready_lvl),
        .tx_empty_lvl(tx_empty_lvl), .rx_enabled(rx_enabled),
        .tx_enabled(tx_enabled), .rx_reset(rx_reset), .tx_reset(tx_reset),
        .idle_timer_start(idle_timer_start), .idle_timer_rearm(),
        .idle_limit(), .gap_length(), .clock_ratio(), .ir_filter(),
        .tx_char_valid(tx_char_valid), .tx_char_data(),
        .tx_char_addr(tx_char_addr), .line_break(line_break),
        .line_mark(line_mark), .bit_tick(), .op_mode(op_mode),
        .clk_src(clk_src), .data_bits(data_bits), .line_cfg(line_cfg),
        .dtr_b(dtr_b), .rts_b(rts_b), .irq(irq));

    ucm_peer i_peer (.ref_clk(ref_clk), .rst_b(rst_b), .ev_req(ev_req),
        .tx_char_valid(tx_char_valid), .ev(ev), .rx_data(rx_data),
        .tx_empty_lvl(tx_empty_lvl), .tx_ready_lvl(tx_ready_lvl),
        .sck_pin(sck_pin));

    // ******************************************************
    // bus tasks
    // ******************************************************
    task automatic wr(input logic [8:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [8:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rdc(input logic [8:0] a, input logic [31:0] e);
        rd(a);
        `CHK(d, e)
    endtask

    task automatic results();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // clock and watchdog
    always #2 ref_clk = ~ref_clk;
    initial begin
        #40000;
        error_cnt++;
        results();
    end

    // ******************************************************
    // test sequence
    // ******************************************************
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        `CHK({dtr_b, rts_b}, 2'b11)
        for (i = 0; i < 7; i++) rdc(reg_at[i], rst_at[i]);
        for (i = 0; i < 7; i++) begin
            wr(reg_at[i], 32'hFFFFFFFF);
            rdc(reg_at[i], max_at[i]);
        end
        for (i = 0; i < 11; i++) begin
            if (i > 3) wr(zero_at[i], 32'hFFFFFFFF);
            rdc(zero_at[i], 32'h0);
        end
        for (i = 0; i < 7; i++) begin
            wr(9'h000, cmd_at[i]);
            `CHK({rx_enabled, tx_enabled, dtr_b, rts_b}, pin_at[i])
        end
        wr(9'h000, 32'hC);
        `CHK({rx_reset, tx_reset}, 2'b11)
        @(posedge ref_clk);
        #1;
        `CHK({rx_reset, tx_reset}, 2'b00)
        // sticky flags
        wr(9'h008, 32'h80);
        ev_req <= 8'hFF;
        @(posedge ref_clk);
        ev_req <= 8'h00;
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK(irq, 1'b1)
        rd(9'h014);
        `CHK(d & 32'h25E5, 32'h25E5)
        rdc(9'h018, 32'h1A5);
        wr(9'h000, 32'h6900);
        rd(9'h014);
        `CHK(d & 32'h25E5, 32'h400)
        `CHK(irq, 1'b0)
        wr(9'h004, 32'h4);
        wr(9'h000, 32'h2000);
        rd(9'h014);
        `CHK(d & 32'h25E5, 32'h0)
        wr(9'h00C, 32'h80);
        rdc(9'h010, 32'h0);
        // mode decode
        for (i = 0; i < 16; i++) begin
            wr(9'h004, i);
            `CHK(op_mode, (i inside {0, 1, 2, 3, 4, 6, 8}) ? i[3:0] : 4'h0)
        end
        for (i = 0; i < 4; i++) begin
            wr(9'h004, i << 4);
            `CHK(clk_src, (i == 2) ? 2'h0 : i[1:0])
            wr(9'h004, i << 6);
            `CHK(data_bits, 4'h5 + i[3:0])
        end
        wr(9'h004, 32'h20000);
        `CHK(data_bits, 4'h9)
        wr(9'h004, 32'h173FFFFF);
        rdc(9'h004, 32'h173FFFFF);
        `CHK(line_cfg, 32'h173FFFFF)
        // address marking
        wr(9'h004, 32'hC00);
        wr(9'h000, 32'h1000);
        wr(9'h01C, 32'hA5);
        `CHK({tx_char_valid, tx_char_addr}, 2'b11)
        wr(9'h004, 32'h0);
        wr(9'h000, 32'h1000);
        wr(9'h01C, 32'h5A);
        `CHK({tx_char_valid, tx_char_addr}, 2'b10)
        // break timing
        wr(9'h004, 32'hC0);
        wr(9'h020, 32'h1);
        wr(9'h01C, 32'h55);
        wr(9'h000, 32'h200);
        `CHK(line_break, 1'b0)
        n = 0;
        while (!line_break && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK({line_break, tx_empty_lvl}, 2'b11)
        wr(9'h000, 32'h400);
        n = 2;
        while (line_break && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK(n >= 140 && n <= 180, 1'b1)
        `CHK(line_mark, 1'b1)
        n = 0;
        while (line_mark && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK(n >= 176 && n <= 196, 1'b1)
        wr(9'h000, 32'h400);
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK({line_break, line_mark}, 2'b00)
        results();
    end
endmodule
